// >>> hw/ztsp_burst_ctr.sv
// Two-bit burst counter with linear or interleaved beat order
`timescale 1ns/100ps
`default_nettype none
module ztsp_burst_ctr
   import ztsp_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic rst_b_in,
   ztsp_burst_if.ctr bif
);
   logic [BURST_W-1:0] start_reg;
   logic [BURST_W-1:0] start_next;
   logic [BURST_W-1:0] cnt_reg;
   logic [BURST_W-1:0] cnt_next;
   logic [BURST_W-1:0] cnt_inc;

   // Beat address from start bits and beat count
   function automatic logic [BURST_W-1:0] beat_bits(input logic [BURST_W-1:0] s,
                                                     input logic [BURST_W-1:0] c,
                                                     input logic ilv);
      beat_bits = ilv ? (s ^ c) : BURST_W'(s + c);
   endfunction

   assign cnt_inc      = BURST_W'(cnt_reg + 2'h1); // Wraps after four beats
   assign bif.low_now  = beat_bits(start_reg, cnt_reg, bif.order);
   assign bif.low_next = beat_bits(start_reg, cnt_inc, bif.order);

   // Next start and count
   always_comb begin
      start_next = start_reg;
      cnt_next   = cnt_reg;
      if (bif.load) begin
         start_next = bif.ext_low;
         cnt_next   = BURST_RESET;
      end else if (bif.advance) begin
         cnt_next = cnt_inc;
      end
   end

   // Counter registers
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         start_reg <= BURST_RESET;
         cnt_reg   <= BURST_RESET;
      end else begin
         start_reg <= start_next;
         cnt_reg   <= cnt_next;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   interleave_step_a: assert property (bif.advance && !bif.load && bif.order ##1 bif.order |->
      (bif.low_now ^ start_reg) == BURST_W'($past(cnt_reg) + 2'h1))
      else $error("Interleaved beat order wrong");
   linear_step_a: assert property (bif.advance && !bif.load && !bif.order ##1 !bif.order |->
      bif.low_now == BURST_W'($past(bif.low_now) + 2'h1))
      else $error("Linear beat did not step by one");
   burst_wrap_a: assert property (bif.load ##1 (bif.advance && !bif.load)[*4] |=>
      bif.low_now == $past(start_reg, 4))
      else $error("Burst did not wrap to its start");
endmodule // ztsp_burst_ctr
`default_nettype wire

// >>> hw/ztsp_port.sv
// Pipelined zero-turnaround SRAM port with burst counter and byte lanes
//
// Contract
// - Selected only with a low, b high, c low
// - Load with select starts read or write
// - Each low strobe writes its own lane
// - All strobes high writes nothing, cycle runs
// - Advance steps counter in a burst, ignores chip selects
// - Burst direction fixed at load time
// - Deselect stops new work, pending completes
// - Data bus released one cycle after deselect
// - Suspended edge ignores all inputs
// - Suspend holds registers and data pins
// - Data bus released from reset
// - Interleaved order XORs start with count
// - Linear order increments modulo four
// - Counter wraps to start after four
`timescale 1ns/100ps
`default_nettype none
module ztsp_port
   import ztsp_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              rst_b_in,
   input  wire logic              clock_suspend_n_in,
   input  wire logic              advance_or_load_in,
   input  wire logic              read_not_write_in,
   input  wire logic              chip_sel_a_n_in,
   input  wire logic              chip_sel_b_in,
   input  wire logic              chip_sel_c_n_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [LANES-1:0]  byte_lane_strobe_n_in,
   input  wire logic              burst_order_select_in,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic [LANES-1:0]  parity_in,
   output logic      [DATA_W-1:0] data_out,
   output logic      [LANES-1:0]  parity_out,
   output logic                   data_oe_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [WORD_W-1:0] mem [DEPTH];   // Storage array, no reset
   ztsp_op_e          op_reg;
   ztsp_op_e          op_next;
   logic [HI_W-1:0]   hi_reg;
   logic [HI_W-1:0]   hi_next;
   logic [LANES-1:0]  lane_reg;
   logic [LANES-1:0]  lane_next;
   logic [WORD_W-1:0] rd_reg;
   logic [WORD_W-1:0] rd_next;
   logic [WORD_W-1:0] wr_word;
   logic [ADDR_W-1:0] xfer_reg;      // Word of the beat now in its data phase
   logic [ADDR_W-1:0] xfer_next;
   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] new_addr;
   logic              run;
   logic              selected;
   logic              do_load;
   logic              do_adv;

   ztsp_burst_if bif ();

   // Lane merge: low strobe takes the new lane, else the old one stays
   function automatic logic [WORD_W-1:0] lane_merge(input logic [WORD_W-1:0] old_w,
                                                     input logic [WORD_W-1:0] new_w,
                                                     input logic [LANES-1:0] strobe_n);
      lane_merge = old_w;
      for (int k = 0; k < LANES; k++) begin
         if (!strobe_n[k]) begin
            lane_merge[k*LANE_W +: LANE_W] = new_w[k*LANE_W +: LANE_W];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input decode
   assign run      = !clock_suspend_n_in; // Low level lets the edge act
   assign selected = !chip_sel_a_n_in && chip_sel_b_in && !chip_sel_c_n_in;
   assign cur_addr = {hi_reg, bif.low_now};

   // Each lane packs its byte with its parity bit at the top
   for (genvar k = 0; k < LANES; k++) begin : g_lane
      assign wr_word[k*LANE_W +: LANE_W] = {parity_in[k], data_in[k*BYTE_W +: BYTE_W]};
      assign data_out[k*BYTE_W +: BYTE_W] = rd_reg[k*LANE_W +: BYTE_W];
      assign parity_out[k] = rd_reg[k*LANE_W + BYTE_W];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle decision and read fetch
   always_comb begin
      op_next   = op_reg;
      hi_next   = hi_reg;
      lane_next = lane_reg;
      rd_next   = rd_reg;
      xfer_next = xfer_reg;
      do_load   = 1'b0;
      do_adv    = 1'b0;
      new_addr  = addr_in;
      if (run) begin
         if (!advance_or_load_in) begin
            if (selected) begin
               op_next   = read_not_write_in ? ZTSP_READ : ZTSP_WRITE;
               hi_next   = addr_in[ADDR_W-1:BURST_W];
               lane_next = byte_lane_strobe_n_in;
               do_load   = 1'b1;
            end else begin
               op_next = ZTSP_IDLE;
            end
         end else if (op_reg != ZTSP_IDLE) begin
            // Direction kept, selects and read_not_write ignored
            lane_next = byte_lane_strobe_n_in;
            do_adv    = 1'b1;
            new_addr  = {hi_reg, bif.low_next};
         end
         // Advance from idle leaves op_reg idle: a no-operation
      end
      // Latched, so a live order pin cannot move a pending write elsewhere
      if (do_load || do_adv) begin
         xfer_next = new_addr;
      end
      if ((do_load || do_adv) && op_next == ZTSP_READ) begin
         rd_next = mem[new_addr];
         // A write landing on this edge to the same word is forwarded
         if (op_reg == ZTSP_WRITE && xfer_reg == new_addr) begin
            rd_next = lane_merge(mem[new_addr], wr_word, lane_reg);
         end
      end
   end

   // Burst counter hookup; only acts on edges that are not suspended
   assign bif.load    = do_load;
   assign bif.advance = do_adv;
   assign bif.order   = burst_order_select_in;
   assign bif.ext_low = addr_in[BURST_W-1:0];

   ztsp_burst_ctr u_burst (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .bif        (bif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; idle from reset so the bus starts released
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         op_reg   <= ZTSP_IDLE;
         hi_reg   <= HI_RESET;
         lane_reg <= STROBE_RESET;
         rd_reg   <= WORD_RESET;
         xfer_reg <= {HI_RESET, BURST_RESET};
      end else begin
         op_reg   <= op_next;
         hi_reg   <= hi_next;
         lane_reg <= lane_next;
         rd_reg   <= rd_next; // Held while suspended
         xfer_reg <= xfer_next;
      end
   end

   // Data phase of a write: address and strobes from the previous edge
   always_ff @(posedge ref_clk_in) begin
      if (run && op_reg == ZTSP_WRITE) begin
         mem[xfer_reg] <= lane_merge(mem[xfer_reg], wr_word, lane_reg);
      end
   end

   // Drive only in the data phase of a read; no turnaround cycle needed
   assign data_oe_out = (op_reg == ZTSP_READ);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence load_read_s;
      run && !advance_or_load_in && selected && read_not_write_in;
   endsequence
   sequence load_write_s;
      run && !advance_or_load_in && selected && !read_not_write_in;
   endsequence
   sequence deselect_s;
      run && !advance_or_load_in && !selected;
   endsequence

   suspend_hold_a: assert property (!run |=> $stable(data_out) && $stable(data_oe_out)
      && $stable(parity_out))
      else $error("Outputs moved during suspend");
   suspend_ignore_a: assert property (!run |=> op_reg == $past(op_reg))
      else $error("Suspended edge changed the operation");
   load_read_a: assert property (load_read_s |=> data_oe_out)
      else $error("Load read did not drive the bus");
   load_write_a: assert property (load_write_s |=> !data_oe_out && op_reg == ZTSP_WRITE)
      else $error("Load write not taken");
   deselect_hiz_a: assert property (deselect_s |=> !data_oe_out)
      else $error("Bus not released after deselect");
   noop_hiz_a: assert property (deselect_s ##1 (run && advance_or_load_in) |=> !data_oe_out)
      else $error("Advance after deselect drove the bus");
   burst_dir_a: assert property (run && advance_or_load_in && op_reg != ZTSP_IDLE
      |=> op_reg == $past(op_reg))
      else $error("Burst changed direction");
   burst_addr_a: assert property (run && advance_or_load_in && op_reg != ZTSP_IDLE
      ##1 $stable(burst_order_select_in) |-> cur_addr == $past(new_addr))
      else $error("Burst did not use the internal address");
   reset_hiz_a: assert property ($rose(rst_b_in) |-> !data_oe_out)
      else $error("Bus driven out of reset");
endmodule // ztsp_port
`default_nettype wire

// >>> inc/ztsp_burst_if.sv
// Carrier between the port control and its burst address counter
`timescale 1ns/100ps
`default_nettype none
interface ztsp_burst_if;
   import ztsp_pkg::*;
   logic               load;      // Capture start bits, clear beat count
   logic               advance;   // Step beat count
   logic               order;     // High: interleaved, low: linear
   logic [BURST_W-1:0] ext_low;   // Low address bits of a load
   logic [BURST_W-1:0] low_now;   // Low bits of the current beat
   logic [BURST_W-1:0] low_next;  // Low bits of the following beat

   modport ctl (output load, output advance, output order, output ext_low,
                input low_now, input low_next);
   modport ctr (input load, input advance, input order, input ext_low,
                output low_now, output low_next);
endinterface
`default_nettype wire

// >>> inc/ztsp_pkg.sv
// Shared constants and types for the zero-turnaround SRAM port
package ztsp_pkg;
   localparam int ADDR_W   = 18;             // Word address width
   localparam int LANES    = 4;              // Byte lanes on the bus
   localparam int BYTE_W   = 8;              // Data bits per lane
   localparam int LANE_W   = BYTE_W + 1;     // Data bits plus parity bit
   localparam int DATA_W   = LANES * BYTE_W; // Data pins
   localparam int WORD_W   = LANES * LANE_W; // Stored word width
   localparam int BURST_W  = 2;              // Low address bits walked by a burst
   localparam int HI_W     = ADDR_W - BURST_W;
   localparam int DEPTH    = 1 << ADDR_W;    // Words in the array
   localparam logic [LANES-1:0]   STROBE_RESET = 4'hf;  // No lane enabled
   localparam logic [BURST_W-1:0] BURST_RESET  = 2'h0;
   localparam logic [HI_W-1:0]    HI_RESET     = 16'h0000;
   localparam logic [WORD_W-1:0]  WORD_RESET   = 36'h000000000;

   // Operation captured at the address phase, acted on in the data phase
   typedef enum logic [1:0] {
      ZTSP_IDLE,
      ZTSP_READ,
      ZTSP_WRITE
   } ztsp_op_e;
endpackage

// >>> testbench/ztsp_ctl_model.sv
// Memory controller model driving the port's address, control and data pins
`timescale 1ns/100ps
`default_nettype none
module ztsp_ctl_model
   import ztsp_pkg::*;
(
   input  wire logic              ref_clk_in,
   output var logic               clock_suspend_n_out,
   output var logic               advance_or_load_out,
   output var logic               read_not_write_out,
   output var logic               chip_sel_a_n_out,
   output var logic               chip_sel_b_out,
   output var logic               chip_sel_c_n_out,
   output var logic [ADDR_W-1:0]  addr_out,
   output var logic [LANES-1:0]   byte_lane_strobe_n_out,
   output var logic               burst_order_select_out,
   output var logic [DATA_W-1:0]  data_out,
   output var logic [LANES-1:0]   parity_out
);
   // Start deselected with the clock edge blocked
   initial begin
      {clock_suspend_n_out, advance_or_load_out, read_not_write_out} = 3'h4;
      {chip_sel_a_n_out, chip_sel_b_out, chip_sel_c_n_out} = 3'h6;
      {addr_out, byte_lane_strobe_n_out, burst_order_select_out} = '0;
      {data_out, parity_out} = '0;
   end

   // One cycle of the controller, launched just after a falling edge
   task automatic drive(input logic sus, input logic adv, input logic rnw, input logic sel, input logic ord,
                        input logic [ADDR_W-1:0] a, input logic [LANES-1:0] s, inout int seed);
      int k;
      @(negedge ref_clk_in);
      k = ($random(seed) & 32'h7fffffff) % 3;
      {clock_suspend_n_out, advance_or_load_out, read_not_write_out} = {sus, adv, rnw};
      // Deselect drops exactly one of the three selects, picked at random
      {chip_sel_a_n_out, chip_sel_b_out, chip_sel_c_n_out} = sel ? 3'h2 : (k == 0 ? 3'h6 : (k == 1 ? 3'h0 : 3'h3));
      {addr_out, byte_lane_strobe_n_out, burst_order_select_out} = {a, s, ord};
      // Data lines change every cycle so a stale beat cannot pass
      data_out = $random(seed);
      parity_out = 4'($random(seed));
   endtask
endmodule // ztsp_ctl_model
`default_nettype wire

// >>> testbench/ztsp_port_tb_top.sv
// Self-checking bench for the zero-turnaround SRAM port
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin err_count++; \
   $display("wrong value at %0t: %s", $time, msg); end end
module ztsp_port_tb_top
   import ztsp_pkg::*;
;
   logic              ref_clk, rst_b, sus, adv, rnw, sa_n, sb, sc_n, ord, oe, o, sel_now;
   logic [ADDR_W-1:0] addr, a;
   logic [LANES-1:0]  stb, par, par_q, exp_p, wstb_m;
   logic [DATA_W-1:0] din, dq, exp_d;
   logic [LANE_W-1:0] mem [16][LANES];
   logic [1:0]        hi_m, start_m, n_m, low_m;
   logic [3:0]        widx_m, idx_m;
   logic              wpend;
   ztsp_op_e          op_m;
   int                err_count, checks, seed, i, k, r;

   ztsp_port u_dut (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .clock_suspend_n_in(sus), .advance_or_load_in(adv),
      .read_not_write_in(rnw), .chip_sel_a_n_in(sa_n), .chip_sel_b_in(sb), .chip_sel_c_n_in(sc_n),
      .addr_in(addr), .byte_lane_strobe_n_in(stb), .burst_order_select_in(ord), .data_in(din),
      .parity_in(par), .data_out(dq), .parity_out(par_q), .data_oe_out(oe));
   ztsp_ctl_model u_ctl (.ref_clk_in(ref_clk), .clock_suspend_n_out(sus), .advance_or_load_out(adv),
      .read_not_write_out(rnw), .chip_sel_a_n_out(sa_n), .chip_sel_b_out(sb), .chip_sel_c_n_out(sc_n),
      .addr_out(addr), .byte_lane_strobe_n_out(stb), .burst_order_select_out(ord), .data_out(din),
      .parity_out(par));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and closing report
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic report_and_stop;
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reference behaviour, stepped on the same edge as the port
   assign sel_now = !sa_n && sb && !sc_n;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         op_m = ZTSP_IDLE;
         wpend = 1'b0;
         {exp_d, exp_p} = '0;
      end else if (!sus) begin
         // Pending write data lands first, so a following read sees it
         for (k = 0; k < LANES; k++)
            if (wpend && !wstb_m[k]) mem[widx_m][k] = {par[k], din[8*k +: 8]};
         wpend = 1'b0;
         if (!adv && sel_now) begin
            op_m = rnw ? ZTSP_READ : ZTSP_WRITE;
            {hi_m, start_m, n_m} = {addr[17:16], addr[1:0], 2'h0};
         end else if (adv && op_m != ZTSP_IDLE)
            n_m = n_m + 2'h1;
         else
            op_m = ZTSP_IDLE;
         low_m = ord ? (start_m ^ n_m) : (start_m + n_m);
         idx_m = {hi_m, low_m};
         if (op_m == ZTSP_WRITE) {wpend, widx_m, wstb_m} = {1'b1, idx_m, stb};
         for (k = 0; k < LANES; k++)
            if (op_m == ZTSP_READ) {exp_p[k], exp_d[8*k +: 8]} = mem[idx_m][k];
      end
   end

   // Outputs settle after the rising edge and are judged at the falling one
   always @(negedge ref_clk) begin
      `CHK(oe, op_m == ZTSP_READ, "bus drive")
      `CHK(dq, exp_d, "read data")
      `CHK(par_q, exp_p, "read parity")
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: fill, directed bursts, then random traffic
   initial begin
      {err_count, checks, o} = '0;
      seed = 32'h140c9f86;
      // A real falling edge once every process waits on it
      rst_b = 1'b1;
      #1 rst_b = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst_b = 1'b1;
      // Fill all words; advances claim read to show direction is latched
      for (i = 0; i < 4; i++) begin
         u_ctl.drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, {i[1:0], 16'h0000}, 4'h0, seed);
         repeat (3) u_ctl.drive(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, '0, 4'h0, seed);
      end
      for (i = 0; i < 8; i++) begin
         a = {i[1:0], 14'h0000, i[1:0]};
         o = i[2];
         u_ctl.drive(1'b0, 1'b0, 1'b1, 1'b1, o, a, 4'h0, seed);
         // Blocked edge that would otherwise load a write
         u_ctl.drive(1'b1, 1'b0, 1'b0, 1'b1, o, ~a, 4'h0, seed);
         repeat (6) u_ctl.drive(1'b0, 1'b1, 1'b0, 1'b0, o, '0, 4'h0, seed);
         u_ctl.drive(1'b0, 1'b0, 1'b1, 1'b0, o, a, 4'h0, seed);
         u_ctl.drive(1'b0, 1'b1, 1'b1, 1'b0, o, a, 4'h0, seed);
         // One lane at a time, then a write that stores nothing
         u_ctl.drive(1'b0, 1'b0, 1'b0, 1'b1, o, a, (i < 4) ? ~(4'h1 << i) : 4'hf, seed);
         u_ctl.drive(1'b0, 1'b0, 1'b1, 1'b1, o, a, 4'h0, seed);
      end
      repeat (3000) begin
         r = $random(seed);
         // Order only moves on a load or deselect so a burst keeps one order
         if (!r[1] && r[5:3] != 3'h0) o = r[2];
         u_ctl.drive(r[5:3] == 3'h0, r[1], r[6], r[8:7] != 2'h0, o, {r[10:9], 14'h0000, r[12:11]}, r[16:13], seed);
      end
      u_ctl.drive(1'b0, 1'b0, 1'b1, 1'b0, o, '0, 4'h0, seed);
      @(negedge ref_clk);
      report_and_stop();
   end

   // Guard against a hung run
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      report_and_stop();
   end
endmodule // ztsp_port_tb_top
`default_nettype wire
